// [inc/cfg_pkg.sv]
/*
  Shared constants and types for the configuration port sequencer.
  Assumes a 10 MHz system clock; all times are turned into cycles here.
*/
`default_nettype none
package cfg_pkg;

  // System clock period
  localparam int SYS_PERIOD_NS     = 100;
  // Shortest restart pulse on the reset pin and its cycle count (rounded up)
  localparam int RESET_MIN_NS      = 200;
  localparam int RESET_MIN_CYCLES  = (RESET_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // Memory clear time after restart release, and its cycle count (rounded up)
  localparam int CLEAR_WAIT_US     = 1200;
  localparam int CLEAR_CYCLES      = (CLEAR_WAIT_US * 1000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // Clock cycles after done before the pins go live (plain default)
  localparam int DONE_IO_CYCLES    = 8;
  // Bytes in one configuration image (plain default)
  localparam int LOAD_BYTES        = 16;
  // System cycles per half period of the master clock (1.25 MHz)
  localparam int MCLK_HALF_CYCLES  = 4;
  // Timer and counter widths
  localparam int TIMER_W           = 24;
  localparam int COUNT_W           = 16;
  // Read command plus 24-bit start address sent to the memory
  localparam int CMD_BITS          = 32;
  localparam logic [31:0] READ_CMD = 32'h03000000;
  // Reset values
  localparam logic [7:0] BYTE_RST  = 8'h00;
  // Index of each pin in the synchroniser bank
  localparam int SY_RST  = 0;
  localparam int SY_MODE = 1;
  localparam int SY_SCK  = 2;
  localparam int SY_MOSI = 3;
  localparam int SY_MISO = 4;
  localparam int SY_CSN  = 5;
  localparam int SY_DONE = 6;
  localparam int SY_N    = 7;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_HOLD    = 6'h01,
    ST_CLEAR   = 6'h02,
    ST_LOAD    = 6'h04,
    ST_DRAIN   = 6'h08,
    ST_IO_WAIT = 6'h10,
    ST_USER    = 6'h20
  } cfg_state_t;

  // The four pins of the first SPI port, one bit each
  typedef struct packed {
    logic serial_clock;
    logic master_out;
    logic master_in;
    logic select_n;
  } port1_bits_t;

endpackage
`default_nettype wire

// [src/cfg_fifo.sv]
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset; DEPTH a power of two.
*/
`timescale 1ns/1ps
`default_nettype none
module cfg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  // Pointers carry one extra bit so full and empty differ
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_ptr_t;

  fifo_ptr_t        st_reg;              // Registered pointers
  fifo_ptr_t        st_next;             // Next pointers
  logic [WIDTH-1:0] mem [DEPTH];         // Storage words
  logic             full;                // No room left
  logic             empty;               // Nothing stored
  logic             push;                // Word accepted
  logic             pop;                 // Word taken

  assign full        = (st_reg.wr[AW] != st_reg.rd[AW])
                       && (st_reg.wr[AW-1:0] == st_reg.rd[AW-1:0]);
  assign empty       = (st_reg.wr == st_reg.rd);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign push        = in_valid_i && !full;
  assign pop         = out_ready_i && !empty;
  // Read data straight from the array: the word is stable while valid holds
  assign out_data_o  = mem[st_reg.rd[AW-1:0]];

  // Pointer advance
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
  end

  // Pointer register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Storage write; no reset needed on data
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[st_reg.wr[AW-1:0]] <= in_data_i;
    end
  end

  occupancy_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_reg.wr - st_reg.rd) <= (AW+1)'(DEPTH)) else $error("fifo occupancy beyond depth");
endmodule
`default_nettype wire

// [src/cfg_sequencer.sv]
/*
  Configuration port sequencer: restart, memory clear wait, image load in master
  or slave mode through a FIFO, done pin, delayed pin activation, then user
  SPI or general I/O on the first SPI port.
  Assumes pins are asynchronous to clk_sys_i and the board resolves the done
  pin and the port pins from the output enables.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Pins go live some clocks after done
// - Master clock starts 1200 us after release
// - Restart input is active low, no pull-up
// - Done pin is open drain, pulled high
// - Port clock pin drives memory clock, then user
// - Master-in pin samples memory data, then user
// - Master-out pin drives memory, then user
// - User SPI takes all four pins; general I/O only when it is off
// - Select pin selects memory, then user
module cfg_sequencer #(
  parameter int CLEAR_CYCLES_P   = cfg_pkg::CLEAR_CYCLES,
  parameter int DONE_IO_CYCLES_P = cfg_pkg::DONE_IO_CYCLES,
  parameter int LOAD_BYTES_P     = cfg_pkg::LOAD_BYTES,
  parameter int FIFO_DEPTH_P     = 16
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire logic                 config_reset_n_i,    // Restart pin, low restarts
  input  wire logic                 master_mode_i,       // Strap: high loads from memory
  input  wire logic                 config_complete_i,   // Done pin level
  output logic                      config_complete_o,   // Done pin drive value
  output logic                      config_complete_oe_o,// Done pin enable
  input  wire cfg_pkg::port1_bits_t port1_i,             // Port pin levels
  output cfg_pkg::port1_bits_t      port1_o,             // Port pin drive values
  output cfg_pkg::port1_bits_t      port1_oe_o,          // Port pin enables
  output logic [7:0]                cfg_data_o,          // Image byte to core
  output logic                      cfg_valid_o,
  input  wire logic                 cfg_ready_i,
  output logic                      load_overrun_o,      // Slave byte lost to full FIFO
  output logic                      io_active_o,         // Pins handed to user logic
  input  wire logic                 user_spi_en_i,       // User SPI owns the port
  input  wire logic                 user_spi_master_i,   // User SPI is master
  input  wire cfg_pkg::port1_bits_t user_o_i,            // User drive values
  input  wire cfg_pkg::port1_bits_t user_oe_i,           // General I/O enables
  output cfg_pkg::port1_bits_t      user_i_o             // Synchronised pin levels
);
  // Whole state of the sequencer
  typedef struct packed {
    logic [cfg_pkg::SY_N-1:0]    sync1;      // First synchroniser stage
    logic [cfg_pkg::SY_N-1:0]    sync2;      // Second stage
    logic [cfg_pkg::SY_N-1:0]    sync3;      // Third stage
    logic [cfg_pkg::SY_N-1:0]    lvl;        // Filtered pin levels
    logic                        sck_prev;   // Last filtered slave clock
    cfg_pkg::cfg_state_t         state;
    logic                        master;     // Captured strap
    logic [cfg_pkg::TIMER_W-1:0] timer;      // Clear wait and clock divider
    logic [cfg_pkg::COUNT_W-1:0] count;      // Bytes loaded or clocks after done
    logic                        sck;        // Master clock level
    logic                        csn;        // Master select level
    logic [cfg_pkg::CMD_BITS-1:0] cmd;       // Command still to send
    logic [5:0]                  cmd_left;   // Command bits left
    logic [7:0]                  byte_sh;    // Incoming bits
    logic [2:0]                  bit_cnt;
    logic                        push;       // Byte waiting for FIFO
    logic [7:0]                  push_data;
    logic                        done;
    logic                        io_active;
    logic                        overrun;
  } seq_t;

  seq_t st_reg;                      // Registered state
  seq_t st_next;                     // Next state
  logic fifo_ready;                  // FIFO can take a byte
  logic [cfg_pkg::SY_N-1:0] raw;     // Asynchronous pin bundle
  logic half_end;                    // Divider half period done
  logic sck_rise;                    // Slave clock rising edge
  logic byte_full;                   // Byte completes this bit
  logic stall;                       // Held byte blocks the master clock

  assign raw = {config_complete_i, port1_i.select_n, port1_i.master_in,
                port1_i.master_out, port1_i.serial_clock, master_mode_i, config_reset_n_i};
  assign half_end = (st_reg.timer == cfg_pkg::TIMER_W'(cfg_pkg::MCLK_HALF_CYCLES - 1));
  assign sck_rise = st_reg.lvl[cfg_pkg::SY_SCK] && !st_reg.sck_prev;
  assign byte_full = (st_reg.bit_cnt == 3'h7);
  // Back-pressure: master waits for FIFO room rather than dropping bytes
  assign stall = st_reg.push && !fifo_ready;

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    // Synchronisers; a level change counts once stages two and three agree
    st_next.sync1 = raw;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    for (int i = 0; i < cfg_pkg::SY_N; i++) begin
      if (st_reg.sync2[i] == st_reg.sync3[i]) begin
        st_next.lvl[i] = st_reg.sync3[i];
      end
    end
    st_next.sck_prev = st_reg.lvl[cfg_pkg::SY_SCK];
    // Held byte leaves once the FIFO takes it
    if (st_reg.push && fifo_ready) begin
      st_next.push = 1'b0;
    end
    case (st_reg.state)
      cfg_pkg::ST_HOLD: begin
        // Release: catch the strap and start the memory clear wait
        if (st_reg.lvl[cfg_pkg::SY_RST]) begin
          st_next.master = st_reg.lvl[cfg_pkg::SY_MODE];
          st_next.timer  = '0;
          st_next.state  = cfg_pkg::ST_CLEAR;
        end
      end
      cfg_pkg::ST_CLEAR: begin
        // No master clock and no slave capture while memory clears
        st_next.timer = st_reg.timer + 1'b1;
        if (st_reg.timer == cfg_pkg::TIMER_W'(CLEAR_CYCLES_P - 1)) begin
          st_next.timer    = '0;
          st_next.cmd      = cfg_pkg::READ_CMD;
          st_next.cmd_left = 6'(cfg_pkg::CMD_BITS);
          st_next.csn      = 1'b0;
          st_next.state    = cfg_pkg::ST_LOAD;
        end
      end
      cfg_pkg::ST_LOAD: begin
        if (st_reg.master && !stall) begin
          // Master clock divider
          st_next.timer = st_reg.timer + 1'b1;
          if (half_end) begin
            st_next.timer = '0;
            st_next.sck   = !st_reg.sck;
            if (st_reg.sck) begin
              // Falling edge: next command bit out, or sample data
              if (st_reg.cmd_left != 6'h00) begin
                st_next.cmd      = {st_reg.cmd[cfg_pkg::CMD_BITS-2:0], 1'b0};
                st_next.cmd_left = st_reg.cmd_left - 1'b1;
              end else begin
                st_next.byte_sh = {st_reg.byte_sh[6:0], st_reg.lvl[cfg_pkg::SY_MISO]};
                st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
                if (byte_full) begin
                  st_next.push      = 1'b1;
                  st_next.push_data = {st_reg.byte_sh[6:0], st_reg.lvl[cfg_pkg::SY_MISO]};
                  st_next.count     = st_reg.count + 1'b1;
                end
              end
            end
          end
        end else if (!st_reg.master && sck_rise && !st_reg.lvl[cfg_pkg::SY_CSN]) begin
          // Slave: host data on the master-out pin, taken on clock rise
          st_next.byte_sh = {st_reg.byte_sh[6:0], st_reg.lvl[cfg_pkg::SY_MOSI]};
          st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
          if (byte_full) begin
            // A host cannot be stalled; a byte that meets a full FIFO is lost
            st_next.overrun   = st_reg.overrun | stall;
            st_next.push      = 1'b1;
            st_next.push_data = {st_reg.byte_sh[6:0], st_reg.lvl[cfg_pkg::SY_MOSI]};
            st_next.count     = st_reg.count + 1'b1;
          end
        end
        if (st_reg.count == cfg_pkg::COUNT_W'(LOAD_BYTES_P)) begin
          // Image complete: release the memory
          st_next.csn   = 1'b1;
          st_next.sck   = 1'b0;
          st_next.timer = '0;
          st_next.state = cfg_pkg::ST_DRAIN;
        end
      end
      cfg_pkg::ST_DRAIN: begin
        // Done only after every byte has reached the core
        if (!st_reg.push && !cfg_valid_o) begin
          st_next.done  = 1'b1;
          st_next.count = '0;
          st_next.state = cfg_pkg::ST_IO_WAIT;
        end
      end
      cfg_pkg::ST_IO_WAIT: begin
        // Count configuration clocks once the done pin reads high
        if (st_reg.lvl[cfg_pkg::SY_DONE]) begin
          if (st_reg.master) begin
            st_next.timer = st_reg.timer + 1'b1;
            if (half_end) begin
              st_next.timer = '0;
              st_next.sck   = !st_reg.sck;
              st_next.count = st_reg.count + {15'h0000, st_reg.sck};
            end
          end else if (sck_rise) begin
            st_next.count = st_reg.count + 1'b1;
          end
        end
        if (st_reg.count == cfg_pkg::COUNT_W'(DONE_IO_CYCLES_P)) begin
          st_next.sck       = 1'b0;
          st_next.io_active = 1'b1;
          st_next.state     = cfg_pkg::ST_USER;
        end
      end
      cfg_pkg::ST_USER: begin
        st_next.state = cfg_pkg::ST_USER;
      end
      default: begin
        st_next.state = cfg_pkg::ST_HOLD;
      end
    endcase
    // Low on the filtered restart level restarts from any state
    if (!st_reg.lvl[cfg_pkg::SY_RST]) begin
      st_next.state     = cfg_pkg::ST_HOLD;
      st_next.done      = 1'b0;
      st_next.io_active = 1'b0;
      st_next.sck       = 1'b0;
      st_next.csn       = 1'b1;
      st_next.count     = '0;
      st_next.bit_cnt   = '0;
      st_next.overrun   = 1'b0;
    end
  end

  // State register; restart level resets low, so no pull-up is assumed on the pin
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg         <= '0;
      st_reg.state   <= cfg_pkg::ST_HOLD;
      st_reg.csn     <= 1'b1;
      st_reg.byte_sh <= cfg_pkg::BYTE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Image FIFO between the load and the core
  cfg_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH_P)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_valid_i  (st_reg.push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (st_reg.push_data),
    .out_valid_o (cfg_valid_o),
    .out_ready_i (cfg_ready_i),
    .out_data_o  (cfg_data_o)
  );

  // Done pin: pulled low while not done, released to the pull-up after
  assign config_complete_o    = 1'b0;
  assign config_complete_oe_o = !st_reg.done;
  assign io_active_o          = st_reg.io_active;
  assign load_overrun_o       = st_reg.overrun;
  assign user_i_o = '{serial_clock: st_reg.lvl[cfg_pkg::SY_SCK],
                      master_out:   st_reg.lvl[cfg_pkg::SY_MOSI],
                      master_in:    st_reg.lvl[cfg_pkg::SY_MISO],
                      select_n:     st_reg.lvl[cfg_pkg::SY_CSN]};

  // Port pin steering: configuration, then user SPI or general I/O
  always_comb begin
    port1_o    = '0;
    port1_oe_o = '0;
    if (st_reg.io_active) begin
      if (!user_spi_en_i) begin
        // General I/O
        port1_o    = user_o_i;
        port1_oe_o = user_oe_i;
      end else begin
        // User SPI: master drives clock, out and select; slave drives
        port1_o = user_o_i;
        port1_oe_o.serial_clock = user_spi_master_i;
        port1_oe_o.master_out   = user_spi_master_i;
        port1_oe_o.select_n     = user_spi_master_i;
        port1_oe_o.master_in    = !user_spi_master_i;
      end
    end else if (st_reg.master && (st_reg.state != cfg_pkg::ST_HOLD)) begin
      // Master load: drive the memory, master-in stays an input
      port1_o.serial_clock    = st_reg.sck;
      port1_o.master_out      = st_reg.cmd[cfg_pkg::CMD_BITS-1];
      port1_o.select_n        = st_reg.csn;
      port1_oe_o.serial_clock = 1'b1;
      port1_oe_o.master_out   = 1'b1;
      port1_oe_o.select_n     = 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  done_low_a: assert property (!(st_reg.state inside {cfg_pkg::ST_HOLD,
    cfg_pkg::ST_CLEAR, cfg_pkg::ST_LOAD, cfg_pkg::ST_DRAIN})
    || (config_complete_oe_o && !config_complete_o))
    else $error("done released before load finished");
  done_pin_a: assert property (
    !config_complete_o && (config_complete_oe_o == !st_reg.done))
    else $error("done pin driven high or enable wrong");
  io_after_done_a: assert property ($rose(io_active_o) |-> st_reg.done
    && $past(st_reg.state == cfg_pkg::ST_IO_WAIT)
    && $past(st_reg.count == cfg_pkg::COUNT_W'(DONE_IO_CYCLES_P)))
    else $error("pins activated without the clock count after done");
  no_io_early_a: assert property (!st_reg.done |-> !io_active_o)
    else $error("pins active while not done");
  clear_quiet_a: assert property (st_reg.state == cfg_pkg::ST_CLEAR |->
    !port1_o.serial_clock)
    else $error("master clock moved during memory clear");
  clear_len_a: assert property ($rose(st_reg.state == cfg_pkg::ST_LOAD) |->
    $past(st_reg.timer == cfg_pkg::TIMER_W'(CLEAR_CYCLES_P - 1)))
    else $error("load began before the clear wait ended");
  restart_low_a: assert property (!st_reg.lvl[cfg_pkg::SY_RST] |=>
    st_reg.state == cfg_pkg::ST_HOLD && !st_reg.done)
    else $error("low restart level did not restart");
  master_pins_a: assert property (st_reg.state == cfg_pkg::ST_LOAD && st_reg.master |->
    port1_oe_o.serial_clock && port1_oe_o.master_out && port1_oe_o.select_n
    && !port1_o.select_n && port1_o.serial_clock == st_reg.sck)
    else $error("memory pins not driven during master load");
  miso_input_a: assert property (!io_active_o |-> !port1_oe_o.master_in)
    else $error("master-in driven during configuration");
  slave_pins_a: assert property (!io_active_o && !st_reg.master |-> port1_oe_o == '0)
    else $error("port driven during slave load");
  gpio_a: assert property (io_active_o && !user_spi_en_i |->
    port1_oe_o == user_oe_i && port1_o == user_o_i)
    else $error("general I/O not passed through");
  csn_release_a: assert property ($rose(st_reg.state == cfg_pkg::ST_DRAIN) |->
    st_reg.csn)
    else $error("memory still selected after load");

  master_done_c: cover property (st_reg.master && $rose(io_active_o));
  slave_done_c: cover property (!st_reg.master && $rose(io_active_o));
  stall_c: cover property (stall && st_reg.master);
  restart_c: cover property (st_reg.state == cfg_pkg::ST_USER ##1 st_reg.state == cfg_pkg::ST_HOLD);
endmodule
`default_nettype wire

// [tb/flash_model.sv]
/*
  Behavioural serial memory that answers the master load.
  Assumes mode-0 framing: command taken on rising clock, data changed after each fall.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input  wire logic        sck_i,   // Memory clock from the port
  input  wire logic        csn_i,   // Select, active low
  input  wire logic        mosi_i,  // Command bits
  output logic             miso_o,  // Image bits
  output logic [31:0]      cmd_o    // Captured command
);
  int         n_bits = 0;  // Falls seen in this frame
  logic [7:0] cur;         // Byte now being sent
  initial miso_o = 1'b0;
  // A new frame starts the count again
  always @(negedge csn_i) begin
    n_bits = 0;
    cmd_o = 32'h0;
  end
  // Released line shows the inverse, so a stale bit cannot pass
  always @(posedge csn_i) miso_o = ~miso_o;
  // Command shifts in MSB first
  always @(posedge sck_i) if (!csn_i && n_bits < 32) cmd_o = {cmd_o[30:0], mosi_i};
  // Byte j is A0+j, MSB first, set after each fall
  always @(negedge sck_i) if (!csn_i) begin
    n_bits++;
    cur = 8'hA0 + 8'((n_bits - 32) / 8);
    if (n_bits >= 32) miso_o = cur[7 - (n_bits - 32) % 8];
  end
endmodule
`default_nettype wire

// [tb/spi_config_port_sequencing_tb.sv]
/*
  Self-checking bench: master load, restart, slave load, pin hand-over.
  Assumes the sequencer and FIFO are compiled with the package first.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_config_port_sequencing_tb;
  localparam int CLR = 20;  // Short clear wait for simulation
  localparam int DIO = 3;   // Clocks from done to live pins
  localparam int NB  = 4;   // Image bytes
  logic clk_sys_i = 0, rst_i = 1, reset_n = 0, mode = 1, ready = 1, spi_en = 0, spi_m = 0;
  logic host_sck = 0, host_mosi = 0, host_csn = 1, miso, done_o, done_oe, valid, ovr, io_act;
  cfg_pkg::port1_bits_t pin, po, poe, uo, uoe, ui;
  logic [7:0]  data;
  logic [31:0] cmd;
  int n_errors = 0, checks_done = 0;
  // Board resolves each port pin from the enables
  assign pin.serial_clock = poe.serial_clock ? po.serial_clock : host_sck;
  assign pin.master_out   = poe.master_out ? po.master_out : host_mosi;
  assign pin.master_in    = poe.master_in ? po.master_in : miso;
  assign pin.select_n     = poe.select_n ? po.select_n : host_csn;
  wire done_pin = done_oe ? done_o : 1'b1;  // Weak pull-up
  cfg_sequencer #(.CLEAR_CYCLES_P(CLR), .DONE_IO_CYCLES_P(DIO), .LOAD_BYTES_P(NB)) DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .config_reset_n_i(reset_n), .master_mode_i(mode),
    .config_complete_i(done_pin), .config_complete_o(done_o), .config_complete_oe_o(done_oe),
    .port1_i(pin), .port1_o(po), .port1_oe_o(poe), .cfg_data_o(data), .cfg_valid_o(valid),
    .cfg_ready_i(ready), .load_overrun_o(ovr), .io_active_o(io_act), .user_spi_en_i(spi_en),
    .user_spi_master_i(spi_m), .user_o_i(uo), .user_oe_i(uoe), .user_i_o(ui));
  flash_model mem (.sck_i(pin.serial_clock), .csn_i(pin.select_n), .mosi_i(pin.master_out),
    .miso_o(miso), .cmd_o(cmd));
  // Clock at 10 MHz
  initial forever #50 clk_sys_i = ~clk_sys_i;
  // One comparison, counted
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Take NB bytes off the core side, base value plus index
  task automatic drain(input logic [7:0] base);
    int k, t;
    k = 0;
    t = 0;
    ready <= 1'b1;
    while (k < NB && t < 6000) begin
      @(negedge clk_sys_i);
      t++;
      if (valid === 1'b1) begin
        check(data, base + 8'(k));
        k++;
      end
    end
    check(k, NB);
  endtask
  // Count cycles from done release to live pins
  task automatic wait_io(input int lo);
    int t;
    t = 0;
    while (done_oe !== 1'b0 && t < 2000) begin @(posedge clk_sys_i); t++; end
    t = 0;
    while (io_act !== 1'b1 && t < 2000) begin @(posedge clk_sys_i); t++; end
    check(io_act, 1);
    check(32'(t >= lo), 1);
  endtask
  // Master load: no clock during clear, command, data, done then pins
  task automatic run_master();
    int t;
    check(done_oe, 1);
    mode <= 1'b1;
    reset_n <= 1'b1;
    t = 0;
    while (po.serial_clock !== 1'b1 && t < 2000) begin @(posedge clk_sys_i); t++; end
    check(32'(t >= CLR), 1);
    check(poe, 4'hD);
    check({po.select_n, done_oe, io_act}, 3'h2);
    drain(8'hA0);
    check(cmd, cfg_pkg::READ_CMD);
    wait_io(DIO * cfg_pkg::MCLK_HALF_CYCLES);
    $display("master load done");
  endtask
  // User mode pin ownership for each SPI setting
  task automatic run_user();
    uo <= 4'h5;
    uoe <= 4'hA;
    spi_en <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    check(poe, 4'hA);
    check(po, 4'h5);
    spi_en <= 1'b1;
    spi_m <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    check(poe, 4'hD);
    spi_m <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    check(poe, 4'h2);
    $display("user pins done");
  endtask
  // Shortest legal restart pulse drops the pins and done; strap now picks slave
  task automatic run_restart();
    mode <= 1'b0;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys_i);  // 200 ns low
    reset_n <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    check({done_oe, io_act, poe}, 6'h20);
    $display("restart done");
  endtask
  // Host sends one byte MSB first on an 800 ns link clock
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      host_mosi <= b[i];
      repeat (4) @(posedge clk_sys_i);
      host_sck <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      host_sck <= 1'b0;
    end
  endtask
  // Slave load buffered in the FIFO while the core stalls
  task automatic run_slave();
    mode <= 1'b0;
    ready <= 1'b0;
    reset_n <= 1'b1;
    repeat (CLR + 10) @(posedge clk_sys_i);  // Host waits out the clear
    host_csn <= 1'b0;
    for (int j = 0; j < NB; j++) send_byte(8'h50 + 8'(j));
    check({poe, valid, ovr}, 6'h2);
    drain(8'h50);
    repeat (8) @(posedge clk_sys_i);  // Done released and seen high, no host clock yet
    check({done_oe, io_act}, 2'h0);
    // Pins go live on the DIO-th host clock after done, not before
    for (int j = 1; j <= DIO; j++) begin
      host_sck <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      host_sck <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      check(io_act, 1'(j == DIO));
    end
    host_csn <= 1'b1;
    $display("slave load done");
  endtask
  // Main sequence
  initial begin
    uo = 4'h0;
    uoe = 4'h0;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    run_master();
    run_user();
    run_restart();
    run_slave();
    end_of_test();
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
